// ==== bench/edge_src.sv ====
/*
 * Reference and feedback edge source standing in for the PLL outside.
 * Assumes edges are one-cycle enables on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module edge_src
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] period,
    input  wire logic [7:0] skew,
    output var  logic       ref_in,
    output var  logic       vco_in
);
    logic [7:0] cnt_q;

    // the lock scenarios keep the period above the unlock window
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_q  <= 8'h00;
            ref_in <= 1'b0;
            vco_in <= 1'b0;
        end
        else
        begin
            cnt_q  <= (cnt_q + 8'h01 >= period) ? 8'h00 : cnt_q + 8'h01;
            ref_in <= cnt_q == 8'h00;
            vco_in <= cnt_q == skew;
        end
    end
endmodule
`default_nettype wire

// ==== bench/lock_ctl_checker.sv ====
/*
 * Port checker for lock_ctl, bound from the bench top.
 * Assumes bus writes are the only way the configuration changes.
 */
`timescale 1ns/1ps
`default_nettype none
module lock_ctl_checker
    import lock_ctl_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        clk_en,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        ref_in,
    input wire logic        vco_in,
    input wire logic        realign_n,
    input wire logic        ref_pfd,
    input wire logic        fb_pfd,
    input wire logic        lock_status_pin,
    input wire logic        lock_status_oe,
    input wire logic        status_pin,
    input wire logic        reference_monitor_pin,
    input wire logic        irq
);
    logic [15:0] cfg_q [16];
    logic [1:0]  age_q;
    logic        settled;

    // mirror of written settings; outputs lag a write, so wait 3 cycles
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 16; i++)
                cfg_q[i] <= 16'h0000;
            age_q <= 2'h0;
        end
        else if (clk_en && wr)
        begin
            cfg_q[addr] <= wdata;
            age_q       <= 2'h0;
        end
        else if (clk_en && age_q != 2'h3)
            age_q <= age_q + 2'h1;
    end
    assign settled = age_q == 2'h3;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst || !clk_en);

    sequence ref_late;
        ##3 ref_pfd;
    endsequence

    chk_rd_quiet: assert property (!rd |=> rdata == 16'h0000)
        else $error("read data not zero outside a read answer");
    chk_rdiv_one: assert property (settled
        && cfg_q[A_RDIV] <= 16'h0001
        && !cfg_q[A_SYNDLY][RDLYEN_BIT] && ref_in |=> ref_pfd)
        else $error("reference divide by one missed an edge");
    chk_ref_delay: assert property (settled
        && cfg_q[A_RDIV] <= 16'h0001 && realign_n
        && cfg_q[A_SYNDLY][3:0] == 4'hA && ref_in |-> ref_late)
        else $error("reference delay code two not three cycles");
    chk_fb_bypass: assert property (settled
        && cfg_q[A_NDIV] == 16'h0100
        && !cfg_q[A_SYNDLY][NDLYEN_BIT] && vco_in |=> fb_pfd)
        else $error("feedback bypass missed an edge");
    chk_realign_irq: assert property (settled
        && cfg_q[A_SYNDLY][7:6] == 2'b11 && cfg_q[A_IRQMSK][3]
        && $fell(realign_n) |-> ##[1:3] irq)
        else $error("realign reset raised no interrupt");
    chk_dld_route: assert property (settled
        && cfg_q[A_ANTIBL][7:2] == SEL_DLD
        && cfg_q[A_MONSEL][4:0] == MON_DLD && cfg_q[A_LDSEL][5:0] == SEL_DLD
        |-> status_pin == reference_monitor_pin
        && status_pin == lock_status_pin)
        else $error("lock indicator differs between pins");
    chk_cmp_polar: assert property (settled
        && cfg_q[A_ANTIBL][7:2] == SEL_CMP_H
        && cfg_q[A_MONSEL][4:0] == MON_CMP_L
        |-> status_pin != reference_monitor_pin)
        else $error("comparator polarities not opposite");
    chk_cs_ground: assert property (settled
        && cfg_q[A_LDSEL][5:0] == SEL_CSRC
        && cfg_q[A_ANTIBL][7:2] == SEL_DLD && !status_pin
        |-> !lock_status_pin)
        else $error("current source pin not grounded without lock");
    chk_pulse_low: assert property (settled
        && cfg_q[A_LDSEL][5:0] == SEL_ALD_N && lock_status_oe
        |-> !lock_status_pin)
        else $error("open-drain pulse drives the pin high");
    chk_irq_mask: assert property (settled && cfg_q[A_IRQMSK] == 16'h0000
        |-> !irq)
        else $error("interrupt raised with all sources masked");
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
/*
 * Self-checking bench for lock_ctl: bus tasks, scenarios and verdict.
 * Assumes edge_src supplies the reference and feedback edges.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import lock_ctl_pkg::*;
;
    logic        ref_clk   = 1'b0;
    logic        sys_rst   = 1'b1;
    logic        clk_en    = 1'b1;
    logic [3:0]  addr      = 4'h0;
    logic [15:0] wdata     = 16'h0000;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic        realign_n = 1'b1;
    logic [7:0]  period    = 8'h10;
    logic [7:0]  skew      = 8'h08;
    logic [15:0] rdata;
    logic        ref_in, vco_in, ref_pfd, fb_pfd, irq;
    logic        lock_status_pin, lock_status_oe;
    logic        status_pin, reference_monitor_pin;
    int          n_errors = 0;
    int          compares = 0;
    int          n_ref    = 0;
    int          n_fb     = 0;
    logic [5:0]  i_modes [4] = '{SEL_CSRC, SEL_ALD_N, SEL_ALD_P, SEL_DLD};

    lock_ctl i_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .ref_in(ref_in), .vco_in(vco_in), .realign_n(realign_n),
        .ref_pfd(ref_pfd), .fb_pfd(fb_pfd), .irq(irq),
        .lock_status_pin(lock_status_pin),
        .lock_status_oe(lock_status_oe), .status_pin(status_pin),
        .reference_monitor_pin(reference_monitor_pin)
    );
    edge_src i_src (.ref_clk(ref_clk), .sys_rst(sys_rst), .period(period),
        .skew(skew), .ref_in(ref_in), .vco_in(vco_in));

    always #25 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        n_ref <= n_ref + int'(ref_pfd);
        n_fb  <= n_fb + int'(fb_pfd);
    end

    task automatic finish_test;
        if (n_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: word %h not %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: bit %b not %b", $time, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_raw(input logic [3:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        rd_raw(a);
        chk_word(rdata, exp);
    endtask

    task automatic set_src(input logic [7:0] p, input logic [7:0] s);
        @(posedge ref_clk);
        period <= p;
        skew   <= s;
    endtask

    task automatic pulse_realign;
        // let the checker's settle time pass so the realign check is live
        repeat (4) @(posedge ref_clk);
        realign_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        realign_n <= 1'b1;
        wait_cyc(4);
    endtask

    task automatic t_realign;
        rd_chk(A_RDIV, {2'b00, RST_RDIV});
        rd_chk(A_CSTERM, {8'h00, RST_CSTERM});
        rd_chk(4'hF, 16'h0000);
        rd_chk(A_SYNDLY, {8'h00, RST_SYNDLY});
        pulse_realign;
        rd_chk(A_IRQST, 16'h0000);
        wr_reg(A_IRQMSK, {12'h000, IRQ_SYNC});
        wr_reg(A_SYNDLY, 16'h00CA);
        pulse_realign;
        chk_bit(irq, 1'b1);
        rd_chk(A_IRQST, {12'h000, IRQ_SYNC});
        chk_bit(irq, 1'b0);
    endtask

    task automatic t_dividers;
        set_src(8'h04, 8'h00);
        wr_reg(A_RDIV, 16'h0004);
        wait_cyc(8);
        n_ref = 0;
        wait_cyc(256);
        chk_bit(n_ref >= 15 && n_ref <= 17, 1'b1);
        wr_reg(A_RDIV, 16'h0000);
        set_src(8'h01, 8'h00);
        // A below B keeps dual modulus valid with a feedback edge every cycle
        wr_reg(A_NDIV, {8'd3, 5'd1, PM_DM2});
        wait_cyc(8);
        n_fb = 0;
        wait_cyc(140);
        chk_bit(n_fb >= 19 && n_fb <= 21, 1'b1);
        wr_reg(A_NDIV, {8'd3, 5'd1, PM_FD2});
        wait_cyc(8);
        n_fb = 0;
        wait_cyc(140);
        chk_bit(n_fb >= 22 && n_fb <= 24, 1'b1);
    endtask

    task automatic t_lock(input logic [1:0] f, input int need);
        wr_reg(A_LDCTL, {9'h000, f, 5'h00});
        set_src(8'h10, 8'h08);
        wait_cyc(64);
        chk_bit(status_pin, 1'b0);
        rd_raw(A_IRQST);
        set_src(8'h10, 8'h00);
        wait_cyc((need - 2) * 16);
        chk_bit(status_pin, 1'b0);
        wait_cyc(64);
        chk_bit(status_pin, 1'b1);
        chk_bit(reference_monitor_pin, 1'b1);
        chk_bit(lock_status_pin, 1'b1);
        rd_chk(A_IRQST, {12'h000, IRQ_LOCK});
    endtask

    task automatic t_hyst;
        set_src(8'h10, 8'h04);
        wait_cyc(160);
        chk_bit(status_pin, 1'b1);
        chk_bit(irq, 1'b0);
        set_src(8'h10, 8'h08);
        wait_cyc(40);
        chk_bit(status_pin, 1'b0);
        rd_chk(A_IRQST, {12'h000, IRQ_UNLOCK});
        wr_reg(A_LDCTL, 16'h0050);
        set_src(8'h10, 8'h02);
        wait_cyc(160);
        chk_bit(status_pin, 1'b0);
        set_src(8'h10, 8'h00);
        wait_cyc(112);
        chk_bit(status_pin, 1'b1);
        set_src(8'h10, 8'h08);
        clk_en <= 1'b0;
        wait_cyc(64);
        chk_bit(status_pin, 1'b1);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        wait_cyc(40);
        chk_bit(status_pin, 1'b0);
    endtask

    task automatic t_pins;
        set_src(8'h10, 8'h08);
        wait_cyc(64);
        wr_reg(A_CSTERM, 16'h0004);
        wr_reg(A_ANTIBL, {8'h00, SEL_CMP_H, 2'b00});
        wr_reg(A_MONSEL, {11'h000, MON_CMP_L});
        wr_reg(A_LDSEL, {10'h000, SEL_CSRC});
        rd_raw(A_IRQST);
        set_src(8'h10, 8'h00);
        wait_cyc(224);
        chk_bit(status_pin, 1'b1);
        chk_bit(reference_monitor_pin, 1'b0);
        rd_chk(A_STAT, 16'h0003);
        rd_chk(A_IRQST, {12'h000, IRQ_LOCK | IRQ_CMP});
        wr_reg(A_ANTIBL, {8'h00, SEL_DLD, 2'b00});
        foreach (i_modes[k])
        begin
            wr_reg(A_LDSEL, {10'h000, i_modes[k]});
            set_src(8'h10, 8'h08);
            wait_cyc(48);
            set_src(8'h10, 8'h00);
            wait_cyc(96);
            chk_bit(lock_status_oe, i_modes[k] == SEL_CSRC
                    || i_modes[k] == SEL_DLD);
        end
        wr_reg(A_IRQMSK, 16'h0000);
        set_src(8'h10, 8'h08);
        wait_cyc(64);
        chk_bit(irq, 1'b0);
    endtask

    initial
    begin
        wait_cyc(1);
        chk_bit(lock_status_oe, 1'b1);
        chk_word(rdata, 16'h0000);
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_realign;
        t_dividers;
        wr_reg(A_SYNDLY, 16'h00C0);
        wr_reg(A_RDIV, 16'h0001);
        wr_reg(A_NDIV, {8'd1, 5'd0, PM_FD1});
        wr_reg(A_CSTERM, 16'h00FF);
        wr_reg(A_IRQMSK, 16'h000F);
        wr_reg(A_ANTIBL, {8'h00, SEL_DLD, 2'b00});
        wr_reg(A_MONSEL, {11'h000, MON_DLD});
        wr_reg(A_LDSEL, {10'h000, SEL_DLD});
        t_lock(2'b00, 5);
        t_lock(2'b10, 3);
        t_hyst;
        t_pins;
        finish_test;
    end

    // the scenarios need about 2500 cycles; sixteen times that means a hang
    initial
    begin
        #2_000_000;
        n_errors++;
        finish_test;
    end
endmodule

bind lock_ctl lock_ctl_checker i_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ref_in(ref_in), .vco_in(vco_in), .realign_n(realign_n),
    .ref_pfd(ref_pfd), .fb_pfd(fb_pfd), .irq(irq),
    .lock_status_pin(lock_status_pin),
    .lock_status_oe(lock_status_oe), .status_pin(status_pin),
    .reference_monitor_pin(reference_monitor_pin)
);
`default_nettype wire

// ==== logic/lock_ctl.sv ====
/*
 * PLL digital control: reference/feedback divider counters with pin reset,
 * delay on both divider outputs, digital lock detect with hysteresis,
 * pulse and current-source lock pin modes, and lock-pin comparator model.
 * Assumes ref_in and vco_in are ref_clk-synchronous edge enables.
 */
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module lock_ctl
    import lock_ctl_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output var  logic [15:0] rdata,
    input  wire logic        ref_in,
    input  wire logic        vco_in,
    input  wire logic        realign_n,
    output var  logic        ref_pfd,
    output var  logic        fb_pfd,
    output var  logic        lock_status_pin,
    output var  logic        lock_status_oe,
    output var  logic        status_pin,
    output var  logic        reference_monitor_pin,
    output var  logic        irq
);
    typedef struct packed {
        logic [7:0]    antibl;
        logic [7:0]    ldctl;
        logic [7:0]    syndly;
        logic [5:0]    ldsel;
        logic [4:0]    monsel;
        logic [13:0]   rdiv;
        logic [15:0]   ndiv;
        logic [7:0]    cs_term;
        logic [3:0]    irq_st;
        logic [3:0]    irq_msk;
        logic [13:0]   rcnt;
        logic [5:0]    pcnt;
        logic [7:0]    bcnt;
        logic [5:0]    acnt;
        logic          dm_hi;
        logic [7:0]    rdel;
        logic [7:0]    ndel;
        det_state_type det;
        logic [7:0]    diff;
        logic [2:0]    cons;
        logic          digital_lock_indicator;
        logic [7:0]    charge;
        logic          cmp;
        logic          realign_q;
        logic [15:0]   rdata;
        logic          ref_pfd;
        logic          fb_pfd;
        logic          ld_pin;
        logic          ld_oe;
        logic          st_pin;
        logic          mon_pin;
        logic          irq;
    } state_type;

    state_type s_q, s_d;

    // prescaler modulus per mode; fixed-divide modes return 1..3
    function automatic logic [5:0] pre_val(input logic [2:0] m);
        case (m)
            PM_FD1:  pre_val = 6'h01;
            PM_FD2:  pre_val = 6'h02;
            PM_FD3:  pre_val = 6'h03;
            PM_DM2:  pre_val = 6'h02;
            PM_DM4:  pre_val = 6'h04;
            PM_DM8:  pre_val = 6'h08;
            PM_DM16: pre_val = 6'h10;
            default: pre_val = 6'h20;
        endcase
    endfunction

    function automatic logic sel_out(input logic [5:0] sel,
                                     input logic d, input logic c);
        case (sel)
            SEL_DLD:   sel_out = d;
            SEL_CMP_H: sel_out = c;
            SEL_CMP_L: sel_out = ~c;
            default:   sel_out = 1'b0;
        endcase
    endfunction

    logic       dm;
    logic [5:0] pval;
    logic [7:0] bval;
    logic [5:0] aval;
    logic       byp_b;
    logic       pdone;
    logic       fb_tick;
    logic       r_tick;
    logic       cnt_rst;
    logic [7:0] win_lock;
    logic [7:0] win_unlk;
    logic [2:0] need;
    logic       cyc_done;
    logic [7:0] cyc_diff;
    logic       ld_sig;
    logic [3:0] ev;

    always_comb
    begin
        s_d = s_q;
        dm = s_q.ndiv[2:0] >= PM_DM2;
        pval = pre_val(s_q.ndiv[2:0]);
        bval = s_q.ndiv[15:8];
        aval = s_q.ndiv[7:3] == 5'h00 ? 6'h00 : {1'b0, s_q.ndiv[7:3]};
        byp_b = bval == 8'h01;
        fb_tick = 1'b0;
        r_tick = 1'b0;
        cyc_done = 1'b0;
        cyc_diff = 8'h00;
        pdone = 1'b0;
        ev = 4'h0;

        // realign pin resets R, A, B together when enabled
        s_d.realign_q = realign_n;
        cnt_rst = (s_q.syndly[SYNRST_LO +: 2] != 2'b00)
                  && !realign_n && s_q.realign_q;
        if (cnt_rst)
            ev = ev | IRQ_SYNC;

        // reference divider: 0 and 1 both divide by one
        if (ref_in)
        begin
            if (s_q.rdiv <= 14'h0001 || s_q.rcnt >= s_q.rdiv - 14'h0001)
            begin
                s_d.rcnt = 14'h0000;
                r_tick = 1'b1;
            end
            else
                s_d.rcnt = s_q.rcnt + 14'h0001;
        end

        // N = P*B + A: A cycles at P+1, remaining B-A cycles at P
        if (vco_in)
        begin
            pdone = s_q.pcnt >= pval - (s_q.dm_hi ? 6'h00 : 6'h01);
            if (pdone)
            begin
                s_d.pcnt = 6'h00;
                if (byp_b)
                    fb_tick = 1'b1;
                else if (s_q.bcnt >= bval - 8'h01)
                begin
                    s_d.bcnt = 8'h00;
                    s_d.acnt = 6'h00;
                    fb_tick = 1'b1;
                end
                else
                    s_d.bcnt = s_q.bcnt + 8'h01;
                if (dm && !byp_b && s_q.acnt < aval)
                    s_d.acnt = s_q.acnt + 6'h01;
            end
            else
                s_d.pcnt = s_q.pcnt + 6'h01;
        end
        // fixed divide ignores A entirely
        s_d.dm_hi = dm && !byp_b && s_d.acnt < aval;

        if (cnt_rst)
        begin
            s_d.rcnt = 14'h0000;
            s_d.acnt = 6'h00;
            s_d.bcnt = 8'h00;
            s_d.pcnt = 6'h00;
            s_d.dm_hi = dm && aval != 6'h00;
            r_tick = 1'b0;
            fb_tick = 1'b0;
        end

        // delay lines: one fast tick per step, bypassed when disabled
        s_d.rdel = {s_q.rdel[6:0], r_tick};
        s_d.ndel = {s_q.ndel[6:0], fb_tick};
        s_d.ref_pfd = s_q.syndly[RDLYEN_BIT]
                      ? s_d.rdel[s_q.syndly[RDLY_LO +: 3]] : r_tick;
        s_d.fb_pfd = s_q.syndly[NDLYEN_BIT]
                     ? s_d.ndel[{2'b00, s_q.syndly[NDLY_LO]}]
                     : fb_tick;

        // thresholds from range bit and anti-backlash width
        win_lock = (s_q.ldctl[LDWIN_BIT] ? WIN_LOCK_LO : WIN_LOCK_HI)
                   + {6'h00, s_q.antibl[ABL_LO +: 2]};
        win_unlk = (s_q.ldctl[LDWIN_BIT] ? WIN_UNLK_LO : WIN_UNLK_HI)
                   + {5'h00, s_q.antibl[ABL_LO +: 2], 1'b0};
        need = 3'h5 - {1'b0, s_q.ldctl[LDCNT_LO +: 2]};

        // measure ticks between paired edges of the two detector inputs
        case (s_q.det)
            DET_IDLE:
            begin
                s_d.diff = 8'h00;
                if (s_d.ref_pfd && s_d.fb_pfd)
                    cyc_done = 1'b1;
                else if (s_d.ref_pfd)
                    s_d.det = DET_REF;
                else if (s_d.fb_pfd)
                    s_d.det = DET_FB;
            end
            DET_REF, DET_FB:
            begin
                if (s_q.diff != DIFF_MAX)
                    s_d.diff = s_q.diff + 8'h01;
                if ((s_q.det == DET_REF && s_d.fb_pfd)
                    || (s_q.det == DET_FB && s_d.ref_pfd))
                begin
                    cyc_done = 1'b1;
                    cyc_diff = s_d.diff;
                    s_d.det = DET_IDLE;
                end
            end
            default: s_d.det = DET_IDLE;
        endcase

        // lock after consecutive good cycles; drop on one bad cycle
        if (cyc_done)
        begin
            if (cyc_diff < win_lock)
            begin
                if (s_q.cons < need)
                    s_d.cons = s_q.cons + 3'h1;
            end
            else
                s_d.cons = 3'h0;
            if (!s_q.digital_lock_indicator && cyc_diff < win_lock && s_q.cons + 3'h1 >= need)
            begin
                s_d.digital_lock_indicator = 1'b1;
                ev = ev | IRQ_LOCK;
            end
            else if (s_q.digital_lock_indicator && cyc_diff > win_unlk)
            begin
                s_d.digital_lock_indicator = 1'b0;
                s_d.cons = 3'h0;
                ev = ev | IRQ_UNLOCK;
            end
        end

        // charge model: grows while locked, cleared at once otherwise
        if (!s_d.digital_lock_indicator)
            s_d.charge = 8'h00;
        else if (cyc_done && s_q.charge != DIFF_MAX)
            s_d.charge = s_q.charge + 8'h01;
        s_d.cmp = s_d.charge >= s_q.cs_term;
        if (s_d.cmp && !s_q.cmp)
            ev = ev | IRQ_CMP;

        // lock pin: open-drain pulse modes, current source, plain selects
        ld_sig = s_q.det != DET_IDLE;
        case (s_q.ldsel)
            SEL_ALD_N:
            begin
                s_d.ld_pin = 1'b0;
                s_d.ld_oe = ld_sig;
            end
            SEL_ALD_P:
            begin
                s_d.ld_pin = 1'b1;
                s_d.ld_oe = ld_sig;
            end
            SEL_CSRC:
            begin
                s_d.ld_pin = s_d.digital_lock_indicator;
                s_d.ld_oe = 1'b1;
            end
            default:
            begin
                s_d.ld_pin = sel_out(s_q.ldsel, s_d.digital_lock_indicator, s_d.cmp);
                s_d.ld_oe = 1'b1;
            end
        endcase
        s_d.st_pin = sel_out(s_q.antibl[STSEL_LO +: 6],
                             s_d.digital_lock_indicator, s_d.cmp);
        s_d.mon_pin = sel_out({1'b0, s_q.monsel},
                              s_d.digital_lock_indicator, s_d.cmp);

        // register port
        s_d.rdata = 16'h0000;
        if (wr)
        begin
            case (addr)
                A_ANTIBL: s_d.antibl = wdata[7:0];
                A_LDCTL:  s_d.ldctl = wdata[7:0];
                A_SYNDLY: s_d.syndly = wdata[7:0];
                A_LDSEL:  s_d.ldsel = wdata[5:0];
                A_MONSEL: s_d.monsel = wdata[4:0];
                A_RDIV:   s_d.rdiv = wdata[13:0];
                A_NDIV:   s_d.ndiv = wdata;
                A_IRQMSK: s_d.irq_msk = wdata[3:0];
                A_CSTERM: s_d.cs_term = wdata[7:0];
                default:  s_d.irq_msk = s_q.irq_msk;
            endcase
        end
        else if (rd)
        begin
            case (addr)
                A_ANTIBL: s_d.rdata = {8'h00, s_q.antibl};
                A_LDCTL:  s_d.rdata = {8'h00, s_q.ldctl};
                A_SYNDLY: s_d.rdata = {8'h00, s_q.syndly};
                A_LDSEL:  s_d.rdata = {10'h000, s_q.ldsel};
                A_MONSEL: s_d.rdata = {11'h000, s_q.monsel};
                A_RDIV:   s_d.rdata = {2'h0, s_q.rdiv};
                A_NDIV:   s_d.rdata = s_q.ndiv;
                A_STAT:   s_d.rdata = {13'h0000, s_q.mon_pin,
                                       s_q.cmp, s_q.digital_lock_indicator};
                A_IRQST:  s_d.rdata = {12'h000, s_q.irq_st};
                A_IRQMSK: s_d.rdata = {12'h000, s_q.irq_msk};
                A_CSTERM: s_d.rdata = {8'h00, s_q.cs_term};
                default:  s_d.rdata = 16'h0000;
            endcase
        end
        // read clears; an event in the same cycle wins over the clear
        if (rd && !wr && addr == A_IRQST)
            s_d.irq_st = ev;
        else
            s_d.irq_st = s_q.irq_st | ev;
        s_d.irq = |(s_d.irq_st & s_d.irq_msk);
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_q <= '0;
            s_q.syndly <= RST_SYNDLY;
            s_q.rdiv <= RST_RDIV;
            s_q.cs_term <= RST_CSTERM;
            s_q.realign_q <= 1'b1;
            s_q.ld_oe <= 1'b1;
            s_q.det <= DET_IDLE;
        end
        else if (clk_en)
            s_q <= s_d;
    end

    assign rdata = s_q.rdata;
    assign ref_pfd = s_q.ref_pfd;
    assign fb_pfd = s_q.fb_pfd;
    assign lock_status_pin = s_q.ld_pin;
    assign lock_status_oe = s_q.ld_oe;
    assign status_pin = s_q.st_pin;
    assign reference_monitor_pin = s_q.mon_pin;
    assign irq = s_q.irq;
endmodule

`default_nettype wire

// ==== logic/lock_ctl_pkg.sv ====
/*
 * Package for the PLL counter-reset and lock-detect block: control field
 * positions, pin output-select codes, window timing constants and states.
 * Assumes a single 20 MHz system clock; register offsets are chosen locally.
 */
package lock_ctl_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_NS = 50;

    // register word addresses
    localparam logic [3:0] A_ANTIBL = 4'h0;  // 0x017
    localparam logic [3:0] A_LDCTL  = 4'h1;  // 0x018
    localparam logic [3:0] A_SYNDLY = 4'h2;  // 0x019
    localparam logic [3:0] A_LDSEL  = 4'h3;  // 0x01A
    localparam logic [3:0] A_MONSEL = 4'h4;  // 0x01B
    localparam logic [3:0] A_RDIV   = 4'h5;
    localparam logic [3:0] A_NDIV   = 4'h6;
    localparam logic [3:0] A_STAT   = 4'h7;
    localparam logic [3:0] A_IRQST  = 4'h8;
    localparam logic [3:0] A_IRQMSK = 4'h9;
    localparam logic [3:0] A_CSTERM = 4'hA;

    // field positions
    localparam int ABL_LO     = 0;   // anti-backlash width [1:0]
    localparam int STSEL_LO   = 2;   // status pin select [7:2]
    localparam int LDCNT_LO   = 5;   // lock count [6:5]
    localparam int LDWIN_BIT  = 4;   // lock window range
    localparam int SYNRST_LO  = 6;   // pin counter reset [7:6]
    localparam int RDLY_LO    = 0;   // reference delay code [2:0]
    localparam int RDLYEN_BIT = 3;
    localparam int NDLY_LO    = 4;   // feedback delay code [4], enable at [5]
    localparam int NDLYEN_BIT = 5;
    localparam int ST_LOCK    = 0;
    localparam int ST_CMP     = 1;
    localparam int ST_REFERENCE_MONITOR_PIN  = 2;

    // output selector codes
    localparam logic [5:0] SEL_DLD    = 6'h01;
    localparam logic [5:0] SEL_ALD_N  = 6'h02;
    localparam logic [5:0] SEL_ALD_P  = 6'h03;
    localparam logic [5:0] SEL_CSRC   = 6'h04;
    localparam logic [5:0] SEL_CMP_H  = 6'h05;
    localparam logic [5:0] SEL_CMP_L  = 6'h06;
    localparam logic [4:0] MON_DLD    = 5'h01;
    localparam logic [4:0] MON_CMP_H  = 5'h05;
    localparam logic [4:0] MON_CMP_L  = 5'h06;

    // reset values
    localparam logic [7:0] RST_SYNDLY = 8'h00;
    localparam logic [13:0] RST_RDIV  = 14'h0001;
    localparam logic [7:0] RST_CSTERM = 8'h10;

    // delay cell: 8 steps over about 1 ns, one step is one fast tick
    localparam int unsigned DLY_TOTAL_PS = 1000;
    localparam int unsigned DLY_STEPS    = 8;

    // lock windows in sampling ticks: lock, unlock wider than lock
    localparam logic [7:0] WIN_LOCK_HI   = 8'h03;
    localparam logic [7:0] WIN_LOCK_LO   = 8'h01;
    localparam logic [7:0] WIN_UNLK_HI   = 8'h06;
    localparam logic [7:0] WIN_UNLK_LO   = 8'h02;
    localparam logic [7:0] DIFF_MAX      = 8'hFF;

    // prescaler modes, field [2:0] of the N control word
    localparam logic [2:0] PM_FD1  = 3'h0;
    localparam logic [2:0] PM_FD2  = 3'h1;
    localparam logic [2:0] PM_FD3  = 3'h2;
    localparam logic [2:0] PM_DM2  = 3'h3;
    localparam logic [2:0] PM_DM4  = 3'h4;
    localparam logic [2:0] PM_DM8  = 3'h5;
    localparam logic [2:0] PM_DM16 = 3'h6;
    localparam logic [2:0] PM_DM32 = 3'h7;

    localparam logic [3:0] IRQ_LOCK   = 4'h1;
    localparam logic [3:0] IRQ_UNLOCK = 4'h2;
    localparam logic [3:0] IRQ_CMP    = 4'h4;
    localparam logic [3:0] IRQ_SYNC   = 4'h8;

    typedef enum logic [1:0]
    {
        DET_IDLE = 2'b00,
        DET_REF  = 2'b01,
        DET_FB   = 2'b10
    } det_state_type;
endpackage
